// [rtl/drv_ctl_defs.vh]
`ifndef DRV_CTL_DEFS_VH
`define DRV_CTL_DEFS_VH

// clock rate
`define CLK_MHZ 25

// control word bit positions (retry enables, output c..e)
`define CW_RETRY_C 8
`define CW_RETRY_D 9
`define CW_RETRY_E 10

// status word bit positions
`define SW_ALWAYS_ONE 15
`define SW_OVER_VOLT 14
`define SW_UNDER_VOLT 13
`define SW_THERM_SHUT 12
`define SW_THERM_WARN 11
`define SW_NOT_READY 10
`define SW_UNUSED 9
`define SW_LOAD_MISSING_E 8
`define SW_NO_ERROR 0

// timing figures in their own units
`define OPEN_LOAD_TIME_US 1000
`define STARTUP_TIME_US 100
`define RETRY_TICK_US 10

// retry delay in retry ticks, short and long duty setting
`define RETRY_SHORT_TICKS 8'h04
`define RETRY_LONG_TICKS 8'h10

// reset values
`define CW_RESET 16'h0000
`define SW_RESET 16'h8000

`endif

// [rtl/retry_channel.v]
`timescale 1ns/1ns
`default_nettype none
`include "drv_ctl_defs.vh"

module retry_channel (
  // clock and reset
  input wire clk,
  input wire resetn,
  // timing and control
  input wire retry_tick,
  input wire retry_enable,
  input wire duty_long,
  input wire clear_req,
  input wire global_off,
  // channel request
  input wire on_req,
  input wire pwm_enable,
  input wire pwm_in,
  input wire overcurrent,
  // results
  output reg oc_flag_q,
  output reg drive_q
);

  reg tripped_q;
  reg will_retry_q;
  reg [7:0] wait_q;

  wire want_on = on_req & (~pwm_enable | pwm_in);
  wire trip = drive_q & overcurrent;
  wire [7:0] delay_ticks = duty_long ? `RETRY_LONG_TICKS : `RETRY_SHORT_TICKS;

  // trip, wait, reactivate; a trip landing on a tick runs one retry anyway
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oc_flag_q <= 1'b0;
      tripped_q <= 1'b0;
      will_retry_q <= 1'b0;
      wait_q <= 8'h00;
      drive_q <= 1'b0;
    end else begin
      if (trip) begin
        oc_flag_q <= 1'b1;
      end else if (clear_req) begin
        oc_flag_q <= 1'b0;
      end
      if (trip) begin
        tripped_q <= 1'b1;
        will_retry_q <= retry_enable | retry_tick;
        wait_q <= 8'h00;
      end else if (clear_req) begin
        tripped_q <= 1'b0;
        will_retry_q <= 1'b0;
      end else if (tripped_q && will_retry_q && retry_tick) begin
        if (wait_q + 8'h01 >= delay_ticks) begin
          tripped_q <= 1'b0;
          will_retry_q <= 1'b0;
        end else begin
          wait_q <= wait_q + 8'h01;
        end
      end
      drive_q <= want_on & ~global_off & ~tripped_q & ~trip;
    end
  end

endmodule
`default_nettype wire

// [rtl/driver_status_control_reg1.v]
`timescale 1ns/1ns
`default_nettype none
`include "drv_ctl_defs.vh"

module driver_status_control_reg1 #(
  parameter OPEN_LOAD_CYCLES = `OPEN_LOAD_TIME_US * `CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // frame exchange, same clock
  input wire frame_done,
  input wire [15:0] control_word_one,
  input wire clear_req,
  input wire duty_long,
  input wire open_load_disable,
  input wire other_errors,
  // per-output requests, same clock (index 0..2 = c, d, e)
  input wire [2:0] on_req,
  input wire [2:0] pwm_enable,
  // analogue monitors and pins, asynchronous
  input wire pwm_in,
  input wire load_supply_over,
  input wire load_supply_under,
  input wire thermal_shutdown,
  input wire thermal_warning,
  input wire active_mode,
  input wire [2:0] overcurrent,
  input wire output_e_high_side_undercurrent,
  // results
  output reg [15:0] status_word_one_q,
  output wire [2:0] oc_flag,
  output wire output_channel_c,
  output wire output_channel_d,
  output wire output_channel_e
);

  localparam [31:0] STARTUP_FULL = `STARTUP_TIME_US * `CLK_MHZ;
  localparam [31:0] TICK_FULL = `RETRY_TICK_US * `CLK_MHZ;
  localparam [31:0] OL_FULL = OPEN_LOAD_CYCLES;
  // counters are 16 bits; every figure fits, so the upper half is cut on purpose
  localparam [15:0] STARTUP_CYCLES = STARTUP_FULL[15:0];
  localparam [15:0] TICK_CYCLES = TICK_FULL[15:0];
  localparam [15:0] OL_LIMIT = OL_FULL[15:0];

  // two-flop synchronisers for every asynchronous input
  reg [9:0] sync1_q;
  reg [9:0] sync2_q;
  wire [9:0] raw_in = {pwm_in, load_supply_over, load_supply_under, thermal_shutdown, thermal_warning,
                       active_mode, overcurrent, output_e_high_side_undercurrent};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end
  wire pwm_s = sync2_q[9];
  wire ov_s = sync2_q[8];
  wire uv_s = sync2_q[7];
  wire tsd_s = sync2_q[6];
  wire twarn_s = sync2_q[5];
  wire active_s = sync2_q[4];
  wire [2:0] oc_s = sync2_q[3:1];
  wire ol_s = sync2_q[0];

  // only the retry enables are stored; bits 15..11 and 7..0 fall away
  reg [2:0] retry_en_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      retry_en_q <= 3'h0;
    end else if (frame_done) begin
      retry_en_q <= {control_word_one[`CW_RETRY_E], control_word_one[`CW_RETRY_D],
                     control_word_one[`CW_RETRY_C]};
    end
  end

  // retry time base, free running so trips land at any phase
  reg [15:0] tick_cnt_q;
  reg retry_tick_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 16'h0000;
      retry_tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 16'h0001) begin
      tick_cnt_q <= 16'h0000;
      retry_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      retry_tick_q <= 1'b0;
    end
  end

  // start-up timer after standby to active
  reg active_prev_q;
  reg not_ready_q;
  reg [15:0] start_cnt_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_prev_q <= 1'b0;
      not_ready_q <= 1'b0;
      start_cnt_q <= 16'h0000;
    end else begin
      active_prev_q <= active_s;
      if (active_s && !active_prev_q) begin
        not_ready_q <= 1'b1;
        start_cnt_q <= 16'h0000;
      end else if (not_ready_q) begin
        if (start_cnt_q == STARTUP_CYCLES - 16'h0001) begin
          not_ready_q <= 1'b0;
        end else begin
          start_cnt_q <= start_cnt_q + 16'h0001;
        end
      end
    end
  end

  // sticky supply and thermal flags; a new event beats a clear in the same cycle
  reg ov_q;
  reg uv_q;
  reg tsd_q;
  reg twarn_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ov_q <= 1'b0;
      uv_q <= 1'b0;
      tsd_q <= 1'b0;
      twarn_q <= 1'b0;
    end else begin
      ov_q <= ov_s | (ov_q & ~clear_req);
      uv_q <= uv_s | (uv_q & ~clear_req);
      tsd_q <= tsd_s | (tsd_q & ~clear_req);
      twarn_q <= twarn_s | (twarn_q & ~clear_req);
    end
  end

  // off in standby and on the wake-up edge itself, so no drive slips out before not-ready rises
  wire standby_hold = ~active_s | ~active_prev_q;
  // warning deliberately absent here: it never switches anything
  wire global_off = ov_q | uv_q | ov_s | uv_s | tsd_q | tsd_s | not_ready_q | standby_hold;

  wire [2:0] drive;
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : chan
      retry_channel u_ch (
        .clk(clk),
        .resetn(resetn),
        .retry_tick(retry_tick_q),
        .retry_enable(retry_en_q[i]),
        .duty_long(duty_long),
        .clear_req(clear_req),
        .global_off(global_off),
        .on_req(on_req[i]),
        .pwm_enable(pwm_enable[i]),
        .pwm_in(pwm_s),
        .overcurrent(oc_s[i]),
        .oc_flag_q(oc_flag[i]),
        .drive_q(drive[i])
      );
    end
  endgenerate
  assign output_channel_c = drive[0];
  assign output_channel_d = drive[1];
  assign output_channel_e = drive[2];

  // open-load filter on output e; a short on-pulse below 1 ms never flags
  reg [15:0] ol_cnt_q;
  reg ol_flag_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ol_cnt_q <= 16'h0000;
      ol_flag_q <= 1'b0;
    end else begin
      if (drive[2] && ol_s) begin
        if (ol_cnt_q != OL_LIMIT) begin
          ol_cnt_q <= ol_cnt_q + 16'h0001;
        end
      end else begin
        ol_cnt_q <= 16'h0000;
      end
      if (drive[2] && ol_s && ol_cnt_q == OL_LIMIT - 16'h0001) begin
        ol_flag_q <= 1'b1;
      end else if (clear_req) begin
        ol_flag_q <= 1'b0;
      end
    end
  end

  // status word assembly, registered
  wire ol_err = ol_flag_q & ~open_load_disable;
  wire any_err = ov_q | uv_q | tsd_q | twarn_q | not_ready_q | ol_err | (|oc_flag) | other_errors;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_word_one_q <= `SW_RESET;
    end else begin
      status_word_one_q <= 16'h0000;
      status_word_one_q[`SW_ALWAYS_ONE] <= 1'b1;
      status_word_one_q[`SW_OVER_VOLT] <= ov_q;
      status_word_one_q[`SW_UNDER_VOLT] <= uv_q;
      status_word_one_q[`SW_THERM_SHUT] <= tsd_q;
      status_word_one_q[`SW_THERM_WARN] <= twarn_q;
      status_word_one_q[`SW_NOT_READY] <= not_ready_q;
      status_word_one_q[`SW_UNUSED] <= 1'b0;
      status_word_one_q[`SW_LOAD_MISSING_E] <= ol_flag_q;
      status_word_one_q[`SW_NO_ERROR] <= ~any_err;
    end
  end

endmodule
`default_nettype wire

// [tb/drv_ctl_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module drv_ctl_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host strobe
  input wire logic clear_req,
  // results
  input wire logic [15:0] status_word_one_q,
  input wire logic [2:0] oc_flag,
  input wire logic output_channel_c,
  input wire logic output_channel_d,
  input wire logic output_channel_e
);
  // short views of the status word and the drives
  wire [15:0] s = status_word_one_q;
  wire on = output_channel_c | output_channel_d | output_channel_e;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // a flag gets one settled cycle before the drives must be off
  a_always_one: assert property (s[15])
    else $error("top bit low");
  a_unused_zero: assert property (!s[9])
    else $error("bit 9 set");
  a_supply_off: assert property ((s[14] | s[13]) && $past(s[14] | s[13]) && !$past(clear_req) |-> !on)
    else $error("drive on in supply fault");
  a_shutdown_off: assert property (s[12] && $past(s[12]) && !$past(clear_req) |-> !on)
    else $error("drive on in shutdown");
  a_shutdown_hold: assert property ($fell(s[12]) |-> $past(clear_req, 2))
    else $error("shutdown flag dropped alone");
  a_not_ready_off: assert property (s[10] && $past(s[10]) |-> !$past(on))
    else $error("drive on while not ready");
  a_trip_off: assert property ($rose(oc_flag[2]) |=> !output_channel_e [*4])
    else $error("tripped output still on");
  a_trip_hold: assert property (|($past(oc_flag) & ~oc_flag) |-> $past(clear_req))
    else $error("trip flag dropped alone");
  a_no_error_bit: assert property ((|s[14:10]) && $stable(s[14:10]) |-> !s[0])
    else $error("no-error bit set with a fault");
  // main scenarios reached
  c_shutdown: cover property ($rose(s[12]));
  c_ready: cover property ($fell(s[10]));
  c_trip: cover property ($rose(oc_flag[2]));
endmodule
bind driver_status_control_reg1 drv_ctl_chk i_chk (.clk(clk), .resetn(resetn), .clear_req(clear_req),
  .status_word_one_q(status_word_one_q), .oc_flag(oc_flag), .output_channel_c(output_channel_c),
  .output_channel_d(output_channel_d), .output_channel_e(output_channel_e));
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock
  input wire logic clk,
  // frame side
  output logic frame_done,
  output logic [15:0] control_word_one,
  output logic clear_req
);
  // idle values at time zero
  initial begin
    frame_done = 1'b0;
    clear_req = 1'b0;
    control_word_one = 16'h0000;
  end
  // word scrambled after its frame, so a stale copy is never seen
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    control_word_one = w;
    frame_done = 1'b1;
    @(negedge clk);
    frame_done = 1'b0;
    control_word_one = ~w;
  endtask
  // reset bit frame
  task automatic clear();
    @(negedge clk);
    clear_req = 1'b1;
    @(negedge clk);
    clear_req = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "drv_ctl_defs.vh"
module tb_top;
  logic clk, resetn, duty_long, open_load_disable, other_errors, pwm_in, active_mode, frame_done, clear_req;
  logic load_supply_over, load_supply_under, thermal_shutdown, thermal_warning, output_e_high_side_undercurrent;
  logic output_channel_c, output_channel_d, output_channel_e;
  logic [2:0] on_req, pwm_enable, overcurrent, oc_flag;
  logic [15:0] control_word_one, status_word_one_q;
  int failures, n_compared, n;
  integer seed, t;
  wire [15:0] outs = {13'h0, output_channel_e, output_channel_d, output_channel_c};
  wire [18:0] pr = {outs[2:0], status_word_one_q};
  host_model i_host (.clk(clk), .frame_done(frame_done), .control_word_one(control_word_one), .clear_req(clear_req));
  driver_status_control_reg1 #(.OPEN_LOAD_CYCLES(20)) i_dut (.clk(clk), .resetn(resetn), .frame_done(frame_done),
    .control_word_one(control_word_one), .clear_req(clear_req), .duty_long(duty_long),
    .open_load_disable(open_load_disable), .other_errors(other_errors), .on_req(on_req), .pwm_enable(pwm_enable),
    .pwm_in(pwm_in), .load_supply_over(load_supply_over), .load_supply_under(load_supply_under),
    .thermal_shutdown(thermal_shutdown), .thermal_warning(thermal_warning), .active_mode(active_mode),
    .overcurrent(overcurrent), .output_e_high_side_undercurrent(output_e_high_side_undercurrent),
    .status_word_one_q(status_word_one_q), .oc_flag(oc_flag), .output_channel_c(output_channel_c),
    .output_channel_d(output_channel_d), .output_channel_e(output_channel_e));
  // expected figures
  function automatic int su();
    return `STARTUP_TIME_US * `CLK_MHZ;
  endfunction
  function automatic int retry_cycles(input logic d);
    return (d ? `RETRY_LONG_TICKS : `RETRY_SHORT_TICKS) * `RETRY_TICK_US * `CLK_MHZ;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // bounded wait on one probe bit, cycles counted in n
  task automatic wt(input int i, input logic v);
    n = 0;
    while (pr[i] !== v) begin
      cyc(1);
      n++;
      if (n > 5000) begin
        failures++;
        tally_and_finish();
      end
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // stimulus, every change on the falling edge
  initial begin
    seed = 32'hff5e9904;
    failures = 0;
    n_compared = 0;
    {resetn, duty_long, open_load_disable, other_errors, pwm_in, active_mode} = 6'h00;
    {load_supply_over, load_supply_under, thermal_shutdown, thermal_warning, output_e_high_side_undercurrent} = 5'h00;
    {on_req, pwm_enable, overcurrent} = 9'h1C0;
    cyc(5);
    chk(status_word_one_q, `SW_RESET);
    resetn = 1'b1;
    active_mode = 1'b1;
    cyc(2);
    chk(outs, 16'h0000);
    wt(`SW_NOT_READY, 1'b1);
    chk(outs, 16'h0000);
    wt(`SW_NOT_READY, 1'b0);
    chk({15'h0, n > su() - 8 && n < su() + 8}, 16'h0001);
    cyc(4);
    chk(outs, 16'h0007);
    thermal_warning = 1'b1;
    cyc(5);
    chk({outs[14:0], status_word_one_q[11]}, 16'h000F);
    thermal_warning = 1'b0;
    cyc(3);
    i_host.clear();
    // supply over, supply under, shutdown; each must outlive its cause
    for (int k = 0; k < 3; k++) begin
      {load_supply_over, load_supply_under, thermal_shutdown} = 3'h4 >> k;
      cyc(2 + $unsigned($random(seed)) % 4);
      {load_supply_over, load_supply_under, thermal_shutdown} = 3'h0;
      cyc(5);
      chk(status_word_one_q & 16'hF801, 16'h8000 | (16'h4000 >> k));
      chk(outs, 16'h0000);
      i_host.clear();
      cyc(4);
      chk(status_word_one_q & 16'hF801, 16'h8001);
      chk(outs, 16'h0007);
    end
    // trips on c and e, retry on e only, random junk in unused bits 15..11
    for (int d = 0; d < 2; d++) begin
      duty_long = d[0];
      t = $random(seed);
      i_host.send({t[15:11], 11'h400});
      overcurrent = 3'h5;
      cyc(4);
      overcurrent = 3'h0;
      chk({13'h0, oc_flag}, 16'h0005);
      chk(outs, 16'h0002);
      wt(18, 1'b1);
      chk({15'h0, n > retry_cycles(d[0]) - 300 && n < retry_cycles(d[0]) + 20}, 16'h0001);
      chk({13'h0, oc_flag}, 16'h0005);
      i_host.clear();
      cyc(4);
      chk(outs, 16'h0007);
    end
    output_e_high_side_undercurrent = 1'b1;
    cyc(30);
    chk(status_word_one_q & 16'h0301, 16'h0100);
    open_load_disable = 1'b1;
    cyc(4);
    chk(status_word_one_q & 16'h0301, 16'h0101);
    other_errors = 1'b1;
    cyc(4);
    chk(status_word_one_q & 16'h0301, 16'h0100);
    pwm_enable = 3'h2;
    repeat (6) begin
      t = $random(seed);
      pwm_in = t[0];
      cyc(5);
      chk(outs, {13'h0, 1'b1, t[0], 1'b1});
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
